//--- verilog/seq_params.svh
// Offsets, field positions, reset values and timing counts of the sequencer control block.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define CTRL6_INDEX       8'h1e
`define CTRL6_ADDR        12'h078
`define STATUS_ADDR       12'h100
`define STROBE_MAP_ADDR   12'h104
`define DELAY_LOW_ADDR    12'h108
`define UNLOCK_ADDR       12'h10c
`define UNLOCK_KEY        8'h7d
`define CTRL6_RESET       8'h00
`define STROBE_MAP_RESET  32'h00000000
`define DELAY_LOW_RESET   8'h00
`define FLD_FIFTH_HI      7
`define FLD_FIFTH_LO      6
`define FLD_SIXTH_HI      5
`define FLD_SIXTH_LO      4
`define FLD_RESERVED      3
`define FLD_UP            2
`define FLD_DOWN          1
`define FLD_INSTANT       0
`define CLK_HZ            20000000
`define MS_PER_SEC        1000
`define TICK_CYCLES       (`CLK_HZ / `MS_PER_SEC)
`define LAST_STROBE       4'h7
`endif

//--- verilog/seq_pkg.sv
// Types shared by the sequencer control block.
`default_nettype none
package seq_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_up   = 3'b010,
    st_down = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [1:0] fifth_interval_select;
    logic [1:0] sixth_interval_select;
    logic       reserved_bit;
    logic       powerup_trigger;
    logic       powerdown_trigger;
    logic       instant_shutdown_select;
  } ctrl6_t;
endpackage : seq_pkg
`default_nettype wire

//--- verilog/ms_tick.sv
// Millisecond tick divider running off the system clock.
`timescale 1ns/1ps
`default_nettype none
module ms_tick #(
  parameter int unsigned CYCLES = 20000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Restart and tick
  input  wire logic restart,
  output logic      tick
);
  if (CYCLES < 2) begin : g_bad_cycles
    $error("ms_tick: CYCLES must be at least 2");
  end

  logic [31:0] cnt_q;

  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule : ms_tick
`default_nettype wire

//--- verilog/power_rail_sequencer_control.sv
// Sequencer control register, APB slave and rail strobe engine.
//
// How it works
// - The control register takes writes only while the unlock key has just been written.
// - Bits 7 to 6 select the fifth interval as 1, 2, 5 or 10 ms, reset 00b.
// - Bits 5 to 4 select the sixth interval with the same coding, reset 00b.
// - Writing 1 to bit 2 starts power-up and the bit clears itself.
// - Writing 1 to bit 1 starts power-down and the bit clears itself.
// - Shutdown begins on the enable pin going low or on the power-down trigger.
// - Shutdown only touches rails that have a nonzero strobe code.
// - With bit 0 clear, rails go off in reverse strobe order with the programmed delays.
// - With bit 0 set, all sequenced rails go off at once with no delays.
// - Bit 3 is reserved, reads 0 and ignores writes.
// - A rail turns on when the strobe count reaches its code; code 0 leaves it alone.
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module power_rail_sequencer_control #(
  parameter int unsigned RAILS       = 8,
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Power pins
  input  wire logic              power_enable_pin,
  output logic      [RAILS-1:0]  rail_enable
);
  // The strobe map word holds four bits per rail, so it cannot serve more than eight rails.
  if (RAILS < 1 || RAILS > 8) begin : g_bad_rails
    $error("RAILS must be 1 to 8");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // ==========================================================
  // Interval decode
  // ==========================================================
  function automatic logic [3:0] interval_ms(input logic [1:0] sel);
    case (sel)
      2'b00:   interval_ms = 4'd1;
      2'b01:   interval_ms = 4'd2;
      2'b10:   interval_ms = 4'd5;
      default: interval_ms = 4'd10;
    endcase
  endfunction : interval_ms

  // ==========================================================
  // Registers
  // ==========================================================
  seq_pkg::ctrl6_t     ctrl_q;
  logic [31:0]         map_q;
  logic [7:0]          dly_low_q;
  logic                unlock_q;
  seq_pkg::seq_state_t state_q;
  logic [3:0]          step_q;
  logic [3:0]          wait_q;
  logic                pin_q;
  logic                up_pend_q;
  logic                down_pend_q;

  wire access  = psel && penable && pready;
  wire wr      = access && pwrite;
  wire rd_next = psel && !penable && !pwrite;
  wire hit_ctrl   = (paddr == `CTRL6_ADDR);
  wire hit_status = (paddr == `STATUS_ADDR);
  wire hit_map    = (paddr == `STROBE_MAP_ADDR);
  wire hit_dly    = (paddr == `DELAY_LOW_ADDR);
  wire hit_unlock = (paddr == `UNLOCK_ADDR);
  wire hit_any    = hit_ctrl || hit_status || hit_map || hit_dly || hit_unlock;
  wire ctrl_wr    = wr && hit_ctrl && unlock_q;

  wire pin_fall  = pin_q && !power_enable_pin;
  wire up_req    = ctrl_wr && pwdata[`FLD_UP];
  wire down_req  = (ctrl_wr && pwdata[`FLD_DOWN]) || pin_fall;

  // ==========================================================
  // Millisecond time base
  // ==========================================================
  logic tick;
  wire  tick_restart = (state_q == seq_pkg::st_idle);

  ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (tick_restart),
    .tick    (tick)
  );

  // Delay between strobe n and n+1 (n = 1..6): fields 1..4 from the neighbour word.
  function automatic logic [1:0] delay_sel(input logic [3:0] n, input logic [7:0] low,
                                           input seq_pkg::ctrl6_t c);
    case (n)
      4'd1:    delay_sel = low[7:6];
      4'd2:    delay_sel = low[5:4];
      4'd3:    delay_sel = low[3:2];
      4'd4:    delay_sel = low[1:0];
      4'd5:    delay_sel = c.fifth_interval_select;
      default: delay_sel = c.sixth_interval_select;
    endcase
  endfunction : delay_sel

  // On the way down, step n leaves strobe n+1 behind, so it waits delay n.
  wire [3:0] wait_len = interval_ms(delay_sel(step_q, dly_low_q, ctrl_q));

  // ==========================================================
  // Rail decode
  // ==========================================================
  logic [RAILS-1:0] on_at_step;
  logic [RAILS-1:0] sequenced;
  always_comb begin
    for (int i = 0; i < RAILS; i++) begin
      sequenced[i]  = (map_q[4*i +: 4] != 4'h0);
      on_at_step[i] = sequenced[i] && (map_q[4*i +: 4] <= step_q);
    end
  end

  // ==========================================================
  // Register writes
  // ==========================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q    <= `CTRL6_RESET;
      map_q     <= `STROBE_MAP_RESET;
      dly_low_q <= `DELAY_LOW_RESET;
      unlock_q  <= 1'b0;
      pin_q     <= 1'b1;
    end else begin
      pin_q <= power_enable_pin;
      if (wr) begin
        unlock_q <= hit_unlock && (pwdata[7:0] == `UNLOCK_KEY);
      end
      if (ctrl_wr) begin
        ctrl_q.fifth_interval_select   <= pwdata[`FLD_FIFTH_HI:`FLD_FIFTH_LO];
        ctrl_q.sixth_interval_select   <= pwdata[`FLD_SIXTH_HI:`FLD_SIXTH_LO];
        ctrl_q.instant_shutdown_select <= pwdata[`FLD_INSTANT];
      end
      ctrl_q.reserved_bit      <= 1'b0;
      // Triggers only ever read back as 0: the engine takes them the same cycle.
      ctrl_q.powerup_trigger   <= 1'b0;
      ctrl_q.powerdown_trigger <= 1'b0;
      if (wr && hit_map) begin
        map_q <= pwdata;
      end
      if (wr && hit_dly) begin
        dly_low_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Strobe engine
  // ==========================================================
  // A request arriving mid-sequence is held until the engine is idle; a held down request is served first and drops a held up request.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= seq_pkg::st_idle;
      step_q      <= 4'h0;
      wait_q      <= 4'h0;
      rail_enable <= '0;
      up_pend_q   <= 1'b0;
      down_pend_q <= 1'b0;
    end else begin
      up_pend_q   <= up_pend_q || up_req;
      down_pend_q <= down_pend_q || down_req;
      case (state_q)
        seq_pkg::st_idle: begin
          if (down_req || down_pend_q) begin
            down_pend_q <= 1'b0;
            up_pend_q   <= 1'b0;
            if (ctrl_q.instant_shutdown_select) begin
              rail_enable <= rail_enable & ~sequenced;
              step_q      <= 4'h0;
            end else begin
              state_q <= seq_pkg::st_down;
              step_q  <= `LAST_STROBE;
              wait_q  <= 4'h0;
            end
          end else if (up_req || up_pend_q) begin
            up_pend_q   <= 1'b0;
            state_q     <= seq_pkg::st_up;
            step_q      <= 4'h1;
            wait_q      <= 4'h0;
          end
        end
        seq_pkg::st_up: begin
          rail_enable <= rail_enable | on_at_step;
          if (tick) begin
            if (step_q == `LAST_STROBE) begin
              state_q <= seq_pkg::st_idle;
            end else if (wait_q + 4'h1 >= wait_len) begin
              step_q <= step_q + 4'h1;
              wait_q <= 4'h0;
            end else begin
              wait_q <= wait_q + 4'h1;
            end
          end
        end
        default: begin
          // Sequenced rails whose code lies above the current step are dropped.
          rail_enable <= rail_enable & ~(sequenced & ~on_at_step);
          if (step_q == 4'h0) begin
            state_q <= seq_pkg::st_idle;
          end else if (tick) begin
            if (wait_q + 4'h1 >= wait_len || step_q == `LAST_STROBE) begin
              step_q <= step_q - 4'h1;
              wait_q <= 4'h0;
            end else begin
              wait_q <= wait_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // APB answer
  // ==========================================================
  wire [31:0] rd_data =
      hit_ctrl   ? {24'h0, ctrl_q} :
      hit_status ? {24'h0, step_q, 1'b0, state_q} :
      hit_map    ? map_q :
      hit_dly    ? {24'h0, dly_low_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      if (rd_next) begin
        prdata <= rd_data;
      end
    end
  end
endmodule : power_rail_sequencer_control
`default_nettype wire

//--- dv/seq_host.sv
// Host processor model driving the control block as an APB master.
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module seq_host (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic hung);
    hung = 1'b1;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && hung; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        hung = 1'b0;
        q    = prdata;
        err  = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so a stale value is never trusted.
    paddr  <= ~a;
    pwdata <= ~d;
  endtask : xfer
  // The key must be the write just before the control write.
  task automatic keyed(input logic [31:0] d, output logic hung);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, `UNLOCK_ADDR, {24'h0, `UNLOCK_KEY}, q, e, hung);
    if (!hung) xfer(1'b1, `CTRL6_ADDR, d, q, e, hung);
  endtask : keyed
endmodule : seq_host
`default_nettype wire

//--- dv/power_rail_sequencer_control_properties.sv
// Port checker for the sequencer control block.
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module seq_ctrl_properties #(
  parameter int unsigned RAILS = 8
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             sys_rst,
  // Bus and rails
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [RAILS-1:0] rail_enable
);
  wire setup  = psel && !penable;
  wire ctl_rd = pready && !pwrite && paddr == `CTRL6_ADDR;
  wire mapped = paddr inside {`CTRL6_ADDR, `STATUS_ADDR, `STROBE_MAP_ADDR,
                              `DELAY_LOW_ADDR, `UNLOCK_ADDR};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  setup_ready_a: assert property (setup |=> pready) else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready) else $error("ready held");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray slave error");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr) else $error("no error");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> rail_enable == '0 && !pready)
    else $error("outputs active in reset");
  reserved_zero_a: assert property (ctl_rd |-> prdata[3] == 1'b0) else $error("bit 3 set");
  trigger_clear_a: assert property (ctl_rd |-> prdata[2:1] == 2'b00)
    else $error("trigger bit reads set");
  cover property (ctl_rd);
  cover property (pready && pslverr);
  cover property (rail_enable != '0 ##1 rail_enable == '0);
endmodule : seq_ctrl_properties
bind power_rail_sequencer_control seq_ctrl_properties #(.RAILS(RAILS)) chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rail_enable(rail_enable));
`default_nettype wire

//--- dv/power_rail_sequencer_control_bench.sv
// Self-checking bench for the sequencer control block.
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module power_rail_sequencer_control_bench;
  logic        clk, sys_rst, power_enable_pin, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rail_enable;
  logic [31:0] q;
  logic        e, h;
  int          n_errors, num_checks, c1;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  seq_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  power_rail_sequencer_control #(.RAILS(8), .TICK_CYCLES(20)) dut (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_enable_pin(power_enable_pin), .rail_enable(rail_enable));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic hang_check();
    if (h) begin
      check("bus answer", 1, 0);
      report_and_stop();
    end
  endtask : hang_check
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    host.xfer(1'b0, a, '0, q, e, h);
    hang_check();
    check("read data", exp, q);
    check("read error", err, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e, h);
    hang_check();
  endtask : wr
  task automatic keyed(input logic [31:0] d);
    host.keyed(d, h);
    hang_check();
  endtask : keyed
  // Counts the cycles until the rails show exactly the given pattern.
  task automatic wait_rails(input logic [7:0] exp, output int cyc);
    cyc = 0;
    while (rail_enable !== exp && cyc < 800) begin
      @(posedge clk);
      cyc++;
    end
    if (cyc >= 800) begin
      check("rails", exp, rail_enable);
      report_and_stop();
    end
  endtask : wait_rails
  task automatic t_reset();
    rd(`CTRL6_ADDR, 32'h0, 1'b0);
    rd(12'h0fc, 32'h0, 1'b1);
    rd(`STATUS_ADDR, 32'h1, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_lock();
    wr(`CTRL6_ADDR, 32'hc0);
    rd(`CTRL6_ADDR, 32'h0, 1'b0);
    wr(`UNLOCK_ADDR, {24'h0, `UNLOCK_KEY});
    wr(`DELAY_LOW_ADDR, 32'h0);
    wr(`CTRL6_ADDR, 32'hc0);
    rd(`CTRL6_ADDR, 32'h0, 1'b0);
    keyed(32'hf8);
    rd(`CTRL6_ADDR, 32'hf0, 1'b0);
    $display("t_lock done");
  endtask : t_lock
  // Rail 0 at strobe 1, rail 1 at strobe 6, rail 3 at strobe 7, rail 2 unsequenced.
  task automatic t_up();
    wr(`STROBE_MAP_ADDR, 32'h7061);
    rd(`STROBE_MAP_ADDR, 32'h7061, 1'b0);
    keyed(32'h74);
    wait_rails(8'h01, c1);
    wait_rails(8'h03, c1);
    check("gap one to six", 1, c1 > 100 && c1 <= 124);
    wait_rails(8'h0b, c1);
    check("gap six to seven", 1, c1 > 180 && c1 <= 204);
    rd(`CTRL6_ADDR, 32'h70, 1'b0);
    $display("t_up done");
  endtask : t_up
  task automatic t_down();
    keyed(32'h72);
    wait_rails(8'h03, c1);
    wait_rails(8'h01, c1);
    check("reverse gap", 1, c1 > 80);
    wait_rails(8'h00, c1);
    rd(`CTRL6_ADDR, 32'h70, 1'b0);
    $display("t_down done");
  endtask : t_down
  task automatic t_instant();
    keyed(32'h75);
    wait_rails(8'h0b, c1);
    power_enable_pin <= 1'b0;
    c1 = 0;
    // A pin fall during power-up is held until the sequence ends, then served.
    while (rail_enable === 8'h0b && c1 < 60) begin
      @(posedge clk);
      c1++;
    end
    check("instant off", 8'h00, rail_enable);
    power_enable_pin <= 1'b1;
    $display("t_instant done");
  endtask : t_instant
  initial begin
    sys_rst          = 1'b1;
    power_enable_pin = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_lock();
    t_up();
    t_down();
    t_instant();
    report_and_stop();
  end
endmodule : power_rail_sequencer_control_bench
`default_nettype wire
